// >>> logic/src_capture_ctrl.sv
// Capture control, status and register file for the alignment input
//
// Summary of operation
// - Polarity bit 0 accepts rising alignment transitions, 1 accepts falling ones.
// - Edge bit 0 samples on sample clock rising edge, 1 on falling.
// - Mode field: 0 off, 1 continuous, 2 counted single; count 0 takes next.
// - Counted mode skips ignore-count valid transitions, then captures the next one.
// - Timestamp delayed by 7-bit count of sample clock cycles, reset 0x40.
// - Hold status is read-only bits 7:4 of the status register, reset zero.
// - Flag reset bit held high keeps setup and hold flags cleared.
// - Setup status is read-only bits 3:0 of the status register.
`timescale 1ns/1ns
`default_nettype none
`include "src_cfg.svh"
module src_capture_ctrl
  import src_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   rst_in,
  input  wire logic [`SRC_ADDR_W-1:0] addr_in,
  input  wire logic [`SRC_DATA_W-1:0] wr_data_in,
  input  wire logic                   wr_in,
  input  wire logic                   rd_in,
  output logic      [`SRC_DATA_W-1:0] rd_data_out,
  input  wire logic                   sysref_in,
  input  wire logic                   sample_clk_in,
  output logic                        capture_out,
  output logic                        timestamp_out,
  output logic                        irq_out
);

  src_bus_t                 bus;
  src_ctrl_t                ctrl_reg;
  src_state_t               state_reg;
  logic [`SRC_IGN_W-1:0]    ignore_reg;
  logic [`SRC_IGN_W-1:0]    skip_reg;
  logic [`SRC_DLY_W-1:0]    delay_reg;
  logic [`SRC_DLY_W-1:0]    dly_cnt_reg;
  logic                     dly_busy_reg;
  logic [`SRC_STAT_W-1:0]   setup_reg;
  logic [`SRC_STAT_W-1:0]   hold_reg;
  logic                     hold_pend_reg;
  logic [`SRC_IRQ_W-1:0]    irq_stat_reg;
  logic [`SRC_IRQ_W-1:0]    irq_mask_reg;
  logic [`SRC_IRQ_W-1:0]    irq_set;
  logic [1:0]               pins_s;
  logic                     srf_s;
  logic                     sclk_s;
  logic                     sclk_last_reg;
  logic                     srf_last_reg;
  logic                     srf_smp_reg;
  logic                     sample_pt;
  logic                     valid_edge;
  logic                     capture_now;
  logic                     stamp_now;
  logic                     srf_change;
  logic                     ctrl_wr;
  logic [1:0]               new_mode;
  logic [`SRC_STAT_W-1:0]   setup_cnt;
  logic [`SRC_STAT_W-1:0]   hold_cnt;
  logic [`SRC_DATA_W-1:0]   rd_mux;

  assign bus = '{addr: addr_in, wr_data: wr_data_in, wr: wr_in, rd: rd_in};

  src_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .async_in ({sysref_in, sample_clk_in}),
    .sync_out (pins_s)
  );

  assign srf_s  = pins_s[1];
  assign sclk_s = pins_s[0];

  // Sampling instant from the chosen sample clock edge
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      sclk_last_reg <= 1'b0;
      srf_last_reg  <= 1'b0;
    end
    else
    begin
      sclk_last_reg <= sclk_s;
      srf_last_reg  <= srf_s;
    end
  end

  assign sample_pt = ctrl_reg.edge_sel ? (sclk_last_reg & ~sclk_s)
                                       : (~sclk_last_reg & sclk_s);
  assign srf_change = srf_s ^ srf_last_reg;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      srf_smp_reg <= 1'b0;
    else if (sample_pt)
      srf_smp_reg <= srf_s;
  end

  assign valid_edge = sample_pt &&
                      (ctrl_reg.polarity ? (srf_smp_reg & ~srf_s)
                                         : (~srf_smp_reg & srf_s));

  // Capture state machine; the polarity change is safe only while idle
  assign ctrl_wr  = bus.wr && (bus.addr == `SRC_ADDR_CTRL);
  assign new_mode = bus.wr_data[`SRC_CTRL_MODE_HI:`SRC_CTRL_MODE_LO];

  assign capture_now = valid_edge && (state_reg == SRC_HUNT) &&
                       ((ctrl_reg.mode == `SRC_MODE_CONT) ||
                        (skip_reg == `SRC_IGNORE_RST));

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_reg <= SRC_IDLE;
      skip_reg  <= `SRC_IGNORE_RST;
    end
    else if (ctrl_wr)
    begin
      // Counted mode re-arms on every control write that selects it
      skip_reg <= ignore_reg;
      if ((new_mode == `SRC_MODE_CONT) || (new_mode == `SRC_MODE_NSHOT))
        state_reg <= SRC_HUNT;
      else
        state_reg <= SRC_IDLE;
    end
    else
    begin
      unique case (state_reg)
        SRC_IDLE: state_reg <= SRC_IDLE;
        SRC_HUNT:
        begin
          if (valid_edge && (ctrl_reg.mode == `SRC_MODE_NSHOT))
          begin
            if (skip_reg == `SRC_IGNORE_RST)
              state_reg <= SRC_DONE;
            else
              skip_reg <= skip_reg - 4'h1;
          end
        end
        SRC_DONE: state_reg <= SRC_DONE;
      endcase
    end
  end

  // Timestamp delay in sample clock cycles; a new capture restarts it
  // A capture that restarts the count drops the stamp still pending
  assign stamp_now = capture_now ? (delay_reg == 7'h00)
                                 : (dly_busy_reg && sample_pt && (dly_cnt_reg == 7'h01));

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      dly_busy_reg <= 1'b0;
      dly_cnt_reg  <= 7'h00;
    end
    else if (capture_now)
    begin
      dly_busy_reg <= (delay_reg != 7'h00);
      dly_cnt_reg  <= delay_reg;
    end
    else if (dly_busy_reg && sample_pt)
    begin
      dly_cnt_reg <= dly_cnt_reg - 7'h01;
      if (dly_cnt_reg == 7'h01)
        dly_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      capture_out   <= 1'b0;
      timestamp_out <= 1'b0;
    end
    else
    begin
      capture_out   <= capture_now;
      timestamp_out <= stamp_now;
    end
  end

  // Setup margin: cycles from the last input change to capture
  src_sat_cnt #(
    .WIDTH (`SRC_STAT_W)
  ) u_setup_cnt (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .clear_in  (srf_change),
    .count_out (setup_cnt)
  );

  // Hold margin: cycles from capture to the next input change
  src_sat_cnt #(
    .WIDTH (`SRC_STAT_W)
  ) u_hold_cnt (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .clear_in  (capture_now),
    .count_out (hold_cnt)
  );

  always_ff @(posedge clock_in)
  begin
    if (rst_in || ctrl_reg.flag_rst)
    begin
      setup_reg     <= `SRC_STAT_RST;
      hold_reg      <= `SRC_STAT_RST;
      hold_pend_reg <= 1'b0;
    end
    else if (capture_now)
    begin
      setup_reg     <= setup_cnt;
      hold_pend_reg <= 1'b1;
    end
    else if (hold_pend_reg && srf_change)
    begin
      hold_reg      <= hold_cnt;
      hold_pend_reg <= 1'b0;
    end
  end

  // Control registers; reserved bits are not stored
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      ctrl_reg   <= '0;
      ignore_reg <= `SRC_IGNORE_RST;
      delay_reg  <= `SRC_DELAY_RST;
    end
    else if (bus.wr)
    begin
      unique case (bus.addr)
        `SRC_ADDR_CTRL:
        begin
          ctrl_reg.flag_rst <= bus.wr_data[`SRC_CTRL_FLAG_RST];
          ctrl_reg.polarity <= bus.wr_data[`SRC_CTRL_POL];
          ctrl_reg.edge_sel <= bus.wr_data[`SRC_CTRL_EDGE];
          ctrl_reg.mode     <= new_mode;
        end
        `SRC_ADDR_IGNORE: ignore_reg <= bus.wr_data[`SRC_IGN_W-1:0];
        `SRC_ADDR_DELAY:  delay_reg  <= bus.wr_data[`SRC_DLY_W-1:0];
        default:          ctrl_reg   <= ctrl_reg;
      endcase
    end
  end

  // Interrupts: hardware set wins over a same-cycle write-one-to-clear
  assign irq_set[`SRC_IRQ_CAPTURE] = capture_now;
  assign irq_set[`SRC_IRQ_STAMP]   = stamp_now;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_out      <= 1'b0;
    end
    else
    begin
      if (bus.wr && (bus.addr == `SRC_ADDR_IRQ_STAT))
        irq_stat_reg <= (irq_stat_reg & ~bus.wr_data[`SRC_IRQ_W-1:0]) | irq_set;
      else
        irq_stat_reg <= irq_stat_reg | irq_set;
      if (bus.wr && (bus.addr == `SRC_ADDR_IRQ_MASK))
        irq_mask_reg <= bus.wr_data[`SRC_IRQ_W-1:0];
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read path; unmapped addresses and reserved bits read zero
  always_comb
  begin
    rd_mux = '0;
    unique case (bus.addr)
      `SRC_ADDR_CTRL:
      begin
        rd_mux[`SRC_CTRL_FLAG_RST] = ctrl_reg.flag_rst;
        rd_mux[`SRC_CTRL_POL]      = ctrl_reg.polarity;
        rd_mux[`SRC_CTRL_EDGE]     = ctrl_reg.edge_sel;
        rd_mux[`SRC_CTRL_MODE_HI:`SRC_CTRL_MODE_LO] = ctrl_reg.mode;
      end
      `SRC_ADDR_IGNORE:   rd_mux[`SRC_IGN_W-1:0] = ignore_reg;
      `SRC_ADDR_DELAY:    rd_mux[`SRC_DLY_W-1:0] = delay_reg;
      `SRC_ADDR_STATUS:
      begin
        rd_mux[`SRC_HOLD_LO+`SRC_STAT_W-1:`SRC_HOLD_LO]   = hold_reg;
        rd_mux[`SRC_SETUP_LO+`SRC_STAT_W-1:`SRC_SETUP_LO] = setup_reg;
      end
      `SRC_ADDR_IRQ_STAT: rd_mux[`SRC_IRQ_W-1:0] = irq_stat_reg;
      `SRC_ADDR_IRQ_MASK: rd_mux[`SRC_IRQ_W-1:0] = irq_mask_reg;
      default:            rd_mux = '0;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      rd_data_out <= '0;
    else if (bus.rd)
      rd_data_out <= rd_mux;
    else
      rd_data_out <= '0;
  end

endmodule // src_capture_ctrl
`default_nettype wire

// >>> logic/src_cfg.svh
// Register map, field positions, reset values and codes of the capture control block
`ifndef SRC_CFG_SVH
`define SRC_CFG_SVH

`define SRC_ADDR_W          12
`define SRC_DATA_W          8
`define SRC_ADDR_CTRL       12'h120
`define SRC_ADDR_IGNORE     12'h121
`define SRC_ADDR_DELAY      12'h123
`define SRC_ADDR_STATUS     12'h128
`define SRC_ADDR_IRQ_STAT   12'h130
`define SRC_ADDR_IRQ_MASK   12'h131

`define SRC_CTRL_FLAG_RST   6
`define SRC_CTRL_POL        4
`define SRC_CTRL_EDGE       3
`define SRC_CTRL_MODE_HI    2
`define SRC_CTRL_MODE_LO    1

`define SRC_MODE_OFF        2'h0
`define SRC_MODE_CONT       2'h1
`define SRC_MODE_NSHOT      2'h2

`define SRC_IGN_W           4
`define SRC_DLY_W           7
`define SRC_STAT_W          4
`define SRC_HOLD_LO         4
`define SRC_SETUP_LO        0

`define SRC_IGNORE_RST      4'h0
`define SRC_DELAY_RST       7'h40
`define SRC_STAT_RST        4'h0

`define SRC_IRQ_W           2
`define SRC_IRQ_CAPTURE     0
`define SRC_IRQ_STAMP       1

`endif

// >>> logic/src_pkg.sv
// Types shared by the capture control block
`default_nettype none
package src_pkg;

  typedef struct packed {
    logic       flag_rst;
    logic       polarity;
    logic       edge_sel;
    logic [1:0] mode;
  } src_ctrl_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wr_data;
    logic        wr;
    logic        rd;
  } src_bus_t;

  typedef enum logic [1:0] {
    SRC_IDLE,
    SRC_HUNT,
    SRC_DONE
  } src_state_t;

endpackage
`default_nettype wire

// >>> logic/src_sync2.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module src_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // src_sync2
`default_nettype wire

// >>> logic/src_sat_cnt.sv
// Saturating cycle counter with synchronous clear
`timescale 1ns/1ns
`default_nettype none
module src_sat_cnt #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             clear_in,
  output logic      [WIDTH-1:0] count_out
);

  always_ff @(posedge clock_in)
  begin
    if (rst_in || clear_in)
      count_out <= '0;
    else if (count_out != {WIDTH{1'b1}})
      count_out <= count_out + {{(WIDTH-1){1'b0}}, 1'b1};
  end

endmodule // src_sat_cnt
`default_nettype wire

// >>> verif/src_clkgen_model.sv
// Model of the clock source driving the alignment pin and the sample clock
`timescale 1ns/1ns
`default_nettype none
module src_clkgen_model #(
  parameter int HALF = 6
) (
  input  wire logic clock_in,
  input  wire logic level_in,
  output var logic  sysref_out,
  output var logic  sample_clk_out
);
  int cnt = 0;

  initial
  begin
    sysref_out = 1'b0;
    sample_clk_out = 1'b0;
  end

  // Sample clock runs free; converter clocks never stop
  always @(posedge clock_in)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      sample_clk_out <= ~sample_clk_out;
    // Pin moves two cycles after a fall, clear of both sampling edges
    if (cnt == 1 && !sample_clk_out)
      sysref_out <= level_in;
  end
endmodule // src_clkgen_model
`default_nettype wire

// >>> verif/src_capture_ctrl_properties.sv
// Port level checks of the capture control block
`timescale 1ns/1ns
`default_nettype none
`include "src_cfg.svh"
module src_capture_ctrl_chk (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  rd_data_out,
  input  wire logic        sysref_in,
  input  wire logic        sample_clk_in,
  input  wire logic        capture_out,
  input  wire logic        timestamp_out,
  input  wire logic        irq_out
);
  logic [7:0] ctrl_reg, ign_reg, dly_reg, msk_reg, exp_rd;
  logic       done_reg, cfg_rd;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Shadow copy of the writable fields, reserved bits dropped
  always_ff @(posedge clock_in)
    if (rst_in)
    begin
      ctrl_reg <= 8'h00;
      ign_reg <= 8'h00;
      dly_reg <= 8'h40;
      msk_reg <= 8'h00;
    end
    else if (wr_in)
      case (addr_in)
        `SRC_ADDR_CTRL: ctrl_reg <= wr_data_in & 8'h5E;
        `SRC_ADDR_IGNORE: ign_reg <= wr_data_in & 8'h0F;
        `SRC_ADDR_DELAY: dly_reg <= wr_data_in & 8'h7F;
        `SRC_ADDR_IRQ_MASK: msk_reg <= wr_data_in & 8'h03;
        default: ;
      endcase

  // Counted mode spent until software rewrites the control register
  always_ff @(posedge clock_in)
    if (rst_in || (wr_in && addr_in == `SRC_ADDR_CTRL))
      done_reg <= 1'b0;
    else if (capture_out && ctrl_reg[2:1] == `SRC_MODE_NSHOT)
      done_reg <= 1'b1;

  always_comb
    case (addr_in)
      `SRC_ADDR_CTRL: exp_rd = ctrl_reg;
      `SRC_ADDR_IGNORE: exp_rd = ign_reg;
      `SRC_ADDR_DELAY: exp_rd = dly_reg;
      `SRC_ADDR_IRQ_MASK: exp_rd = msk_reg;
      default: exp_rd = 8'h00;
    endcase

  assign cfg_rd = rd_in && addr_in != `SRC_ADDR_STATUS && addr_in != `SRC_ADDR_IRQ_STAT;

  sequence s_cfg_read;
    cfg_rd;
  endsequence
  sequence s_stat_read_held;
    rd_in && addr_in == `SRC_ADDR_STATUS && $past(ctrl_reg[6]);
  endsequence

  a_read_back: assert property (s_cfg_read |=> rd_data_out == $past(exp_rd))
    else $error("config read data wrong");
  a_rd_idle: assert property (!$past(rd_in) |-> rd_data_out == 8'h00)
    else $error("read data not zero outside read");
  a_flag_clear: assert property (s_stat_read_held |=> rd_data_out == 8'h00)
    else $error("status not cleared under flag reset");
  a_mode_off: assert property ($past(ctrl_reg[2:1] == 2'h0 || ctrl_reg[2:1] == 2'h3)
    |-> !capture_out)
    else $error("capture while mode off");
  a_nshot_once: assert property (done_reg && ctrl_reg[2:1] == `SRC_MODE_NSHOT
    |-> !capture_out)
    else $error("second capture in counted mode");
  a_stamp_zero: assert property (capture_out && dly_reg == 8'h00 && $past(dly_reg) == 8'h00
    |-> timestamp_out)
    else $error("zero delay stamp missing");
  a_stamp_late: assert property (capture_out && dly_reg != 8'h00 && $past(dly_reg) != 8'h00
    |-> !timestamp_out)
    else $error("stamp not delayed");
  a_irq_raise: assert property (capture_out && msk_reg[0] |=> irq_out)
    else $error("interrupt not raised");
  a_irq_masked: assert property ($past(msk_reg) == 8'h00 |-> !irq_out)
    else $error("masked interrupt raised");
  a_cap_pulse: assert property (capture_out |=> !capture_out [*3])
    else $error("capture pulse too long");
endmodule // src_capture_ctrl_chk
`default_nettype wire

// >>> verif/src_capture_ctrl_tb.sv
// Self-checking testbench of the capture control block
`timescale 1ns/1ns
`default_nettype none
`include "src_cfg.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, (a), (b)); end end
module src_capture_ctrl_tb;
  localparam int HALF = 6;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdat = 8'h00;
  logic [7:0]  last = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        lvl = 1'b0;
  logic        sys_d = 1'b0;
  wire logic [7:0] rdat;
  wire logic   sysref, sclk, cap, stamp, irq;
  int fail_count = 0, checks = 0, ncap = 0, nstamp = 0;
  int cyc = 0, cap_t = 0, chg_t = 0, stamp_t = 0, n0, hit, w;
  logic [7:0] ign [3] = '{8'h00, 8'h03, 8'h0F};
  logic [7:0] dly [2] = '{8'h01, 8'h7F};

  always #4 clock_in = ~clock_in;

  src_capture_ctrl DUT (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat), .sysref_in(sysref),
    .sample_clk_in(sclk), .capture_out(cap), .timestamp_out(stamp), .irq_out(irq));
  src_clkgen_model #(.HALF(HALF)) u_gen (.clock_in(clock_in), .level_in(lvl),
    .sysref_out(sysref), .sample_clk_out(sclk));

  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    sys_d <= sysref;
    if (sysref !== sys_d)
      chg_t <= cyc;
    if (cap === 1'b1)
      ncap <= ncap + 1;
    if (cap === 1'b1)
      cap_t <= cyc;
    if (stamp === 1'b1)
      nstamp <= nstamp + 1;
    if (stamp === 1'b1)
      stamp_t <= cyc;
  end

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clock_in);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_in);
    rd <= 1'b0;
    #1;
    last = rdat;
    `CHK(rdat & m, e)
  endtask

  // Pin level change, then long enough for the slower sampling edge
  task automatic step(input logic v);
    lvl <= v;
    repeat (30) @(posedge clock_in);
  endtask

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    rd_reg(`SRC_ADDR_CTRL, 8'h00, 8'hFF);
    rd_reg(`SRC_ADDR_IGNORE, 8'h00, 8'hFF);
    rd_reg(`SRC_ADDR_DELAY, 8'h40, 8'hFF);
    rd_reg(`SRC_ADDR_STATUS, 8'h00, 8'hFF);
    rd_reg(12'h122, 8'h00, 8'hFF);
    wr_reg(`SRC_ADDR_CTRL, 8'hA1);
    rd_reg(`SRC_ADDR_CTRL, 8'h00, 8'hFF);
    wr_reg(`SRC_ADDR_IGNORE, 8'hFF);
    rd_reg(`SRC_ADDR_IGNORE, 8'h0F, 8'hFF);
    wr_reg(`SRC_ADDR_DELAY, 8'hFF);
    rd_reg(`SRC_ADDR_DELAY, 8'h7F, 8'hFF);
    wr_reg(`SRC_ADDR_STATUS, 8'hFF);
    rd_reg(`SRC_ADDR_STATUS, 8'h00, 8'hFF);
    step(1'b1);
    step(1'b0);
    wr_reg(`SRC_ADDR_CTRL, 8'h06);
    step(1'b1);
    step(1'b0);
    `CHK(ncap, 0)
    wr_reg(`SRC_ADDR_DELAY, 8'h00);
    wr_reg(`SRC_ADDR_IRQ_MASK, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(`SRC_ADDR_CTRL, 8'h00);
      wr_reg(`SRC_ADDR_CTRL, {3'b000, i[1], 4'h0});
      wr_reg(`SRC_ADDR_CTRL, {3'b000, i[1], i[0], 3'b010});
      n0 = ncap;
      step(1'b1);
      `CHK(ncap - n0, i[1] ? 0 : 1)
      if (!i[1])
        `CHK(cap_t - chg_t > 10, i[0] == 1)
      step(1'b0);
      `CHK(ncap - n0, 1)
      if (i[1])
        `CHK(cap_t - chg_t > 10, i[0] == 1)
    end
    wr_reg(`SRC_ADDR_CTRL, 8'h00);
    wr_reg(`SRC_ADDR_CTRL, 8'h02);
    step(1'b1);
    step(1'b0);
    rd_reg(`SRC_ADDR_STATUS, 8'hF0, 8'hF0);
    `CHK(last[3:0] != 4'h0, 1'b1)
    wr_reg(`SRC_ADDR_CTRL, 8'h42);
    step(1'b1);
    step(1'b0);
    rd_reg(`SRC_ADDR_STATUS, 8'h00, 8'hFF);
    rd_reg(`SRC_ADDR_IRQ_STAT, 8'h03, 8'hFF);
    `CHK(irq, 1'b1)
    wr_reg(`SRC_ADDR_IRQ_STAT, 8'h03);
    rd_reg(`SRC_ADDR_IRQ_STAT, 8'h00, 8'hFF);
    `CHK(irq, 1'b0)
    foreach (ign[k])
    begin
      wr_reg(`SRC_ADDR_IGNORE, ign[k]);
      wr_reg(`SRC_ADDR_CTRL, 8'h04);
      n0 = ncap;
      hit = 0;
      for (int p = 1; p <= ign[k] + 2; p++)
      begin
        step(1'b1);
        step(1'b0);
        if (ncap != n0 && hit == 0)
          hit = p;
      end
      `CHK(ncap - n0, 1)
      `CHK(hit, ign[k] + 1)
    end
    wr_reg(`SRC_ADDR_CTRL, 8'h02);
    foreach (dly[k])
    begin
      wr_reg(`SRC_ADDR_DELAY, dly[k]);
      n0 = nstamp;
      lvl <= 1'b1;
      for (w = 0; w < 2000 && nstamp == n0; w++)
        @(posedge clock_in);
      `CHK(nstamp != n0, 1'b1)
      if (nstamp == n0)
        end_sim();
      `CHK(stamp_t - cap_t, 2 * HALF * dly[k])
      step(1'b0);
    end
    end_sim();
  end
endmodule // src_capture_ctrl_tb

bind src_capture_ctrl src_capture_ctrl_chk u_chk (.clock_in(clock_in), .rst_in(rst_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .sysref_in(sysref_in), .sample_clk_in(sample_clk_in),
  .capture_out(capture_out), .timestamp_out(timestamp_out), .irq_out(irq_out));
`default_nettype wire
